/* File: include/irq_map_defs.svh */
// register offsets, field layout, vector addresses and reset values for the interrupt map
`ifndef IRQ_MAP_DEFS_SVH
`define IRQ_MAP_DEFS_SVH
`define IRQ_NUM_LINES 24
`define IRQ_LEVEL_REGS 6
`define IRQ_LEVEL_BASE 8'h00
`define IRQ_PEND_OFFSET 8'h18
`define IRQ_GRANT_OFFSET 8'h1C
`define IRQ_ACK_OFFSET 8'h20
`define IRQ_LEVEL_RESET 8'hFF
`define IRQ_VECTOR_TOP 16'hFFFA
`define IRQ_VECTOR_STEP 16'h0002
`define IRQ_LEVEL_W 2
`define IRQ_OKAY 2'h0
`define IRQ_DECERR 2'h3
`endif

/* File: include/irq_map_pkg.sv */
// types shared by the interrupt map
package irq_map_pkg;
	typedef logic [1:0] level_t;
	typedef logic [4:0] req_num_t;
	typedef logic [15:0] vector_t;
	typedef enum logic [1:0] {rd_idle, rd_resp} rd_state_t;
endpackage : irq_map_pkg

/* File: core/irq_priority_pick.sv */
// picks the lowest-numbered pending request among those of the best (lowest-value) level
`include "irq_map_defs.svh"
module irq_priority_pick (
	input wire logic [23:0] pend,
	input wire logic [47:0] levels,
	output logic found,
	output irq_map_pkg::req_num_t num,
	output irq_map_pkg::level_t level
);
	always_comb
	begin
		found = 1'b0;
		num = 5'h00;
		level = 2'h3;
		// scan high to low so the lowest number wins a tie at equal level
		for (int i = `IRQ_NUM_LINES - 1; i >= 0; i--)
		begin
			if (pend[i] && (!found || levels[2*i +: 2] <= level))
			begin
				found = 1'b1;
				num = 5'(i);
				level = levels[2*i +: 2];
			end
		end
	end
endmodule : irq_priority_pick

/* File: core/irq_vector_map.sv */
// interrupt source mapping: shared request lines, level registers, priority and vector address
// Functional notes
// - each request line has a two-byte vector, line 0 at FFFA/FFFB, two lower each line
// - external channels n and n+4 share request line n for n 0..3
// - each line has a two-bit level field, four per register over six registers
// - at equal level the lowest pending request number is served first
// - request 16 is reload timer 1 or pulse generator write timing or i2c 0
// - request 17 merges 16-bit pulse timer 1 and position detect; 4 merges uart and trip
// - composite timer 0 lower/upper on 5/6; timer 1 upper 14, lower 22
//
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`include "irq_map_defs.svh"
module irq_vector_map (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic clk_en,
	input wire logic [7:0] ext_irq,
	input wire logic uart0_irq,
	input wire logic dead_time_trip_input_irq,
	input wire logic ctimer0_lo_irq,
	input wire logic ctimer0_hi_irq,
	input wire logic lin_rx_irq,
	input wire logic lin_tx_irq,
	input wire logic pulse1_lo_irq,
	input wire logic pulse1_hi_irq,
	input wire logic pulse2_hi_irq,
	input wire logic pulse0_hi_irq,
	input wire logic pulse0_lo_irq,
	input wire logic ctimer1_hi_irq,
	input wire logic pulse2_lo_irq,
	input wire logic reload1_irq,
	input wire logic multi_pulse_generator_write_irq,
	input wire logic i2c0_irq,
	input wire logic programmable_pulse_unit1_irq,
	input wire logic multi_pulse_generator_position_irq,
	input wire logic adc_irq,
	input wire logic timebase_irq,
	input wire logic watch_irq,
	input wire logic comp0_irq,
	input wire logic comp1_irq,
	input wire logic ctimer1_lo_irq,
	input wire logic flash_irq,
	output logic irq_valid,
	output irq_map_pkg::req_num_t irq_num,
	output irq_map_pkg::level_t irq_level,
	output irq_map_pkg::vector_t irq_vector,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	logic [23:0] raw;
	logic [23:0] sync1;
	logic [23:0] sync2;
	logic [7:0] level_reg [0:5];
	logic [47:0] levels;
	logic found;
	irq_map_pkg::req_num_t pick_num;
	irq_map_pkg::level_t pick_level;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic aw_have;
	logic w_have;
	logic do_write;
	logic [1:0] next_bresp;
	irq_map_pkg::rd_state_t rd_state;
	logic [2:0] rd_index;

	// source grouping onto request lines
	always_comb
	begin
		raw[0] = ext_irq[0] | ext_irq[4];
		raw[1] = ext_irq[1] | ext_irq[5];
		raw[2] = ext_irq[2] | ext_irq[6];
		raw[3] = ext_irq[3] | ext_irq[7];
		raw[4] = uart0_irq | dead_time_trip_input_irq;
		raw[5] = ctimer0_lo_irq;
		raw[6] = ctimer0_hi_irq;
		raw[7] = lin_rx_irq;
		raw[8] = lin_tx_irq;
		raw[9] = pulse1_lo_irq;
		raw[10] = pulse1_hi_irq;
		raw[11] = pulse2_hi_irq;
		raw[12] = pulse0_hi_irq;
		raw[13] = pulse0_lo_irq;
		raw[14] = ctimer1_hi_irq;
		raw[15] = pulse2_lo_irq;
		raw[16] = reload1_irq | multi_pulse_generator_write_irq | i2c0_irq;
		raw[17] = programmable_pulse_unit1_irq | multi_pulse_generator_position_irq;
		raw[18] = adc_irq;
		raw[19] = timebase_irq | watch_irq;
		raw[20] = comp0_irq;
		raw[21] = comp1_irq;
		raw[22] = ctimer1_lo_irq;
		raw[23] = flash_irq;
	end

	// sources may come from other clocks, so each line is synchronised
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			sync1 <= 24'h000000;
			sync2 <= 24'h000000;
		end
		else if (clk_en)
		begin
			sync1 <= raw;
			sync2 <= sync1;
		end
	end

	genvar g;
	generate
		for (g = 0; g < `IRQ_LEVEL_REGS; g++)
		begin : lvl
			assign levels[8*g +: 8] = level_reg[g];
		end
	endgenerate

	irq_priority_pick u_pick (
		.pend(sync2),
		.levels(levels),
		.found(found),
		.num(pick_num),
		.level(pick_level)
	);

	// registered request to the core, levels are sampled with the pick
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			irq_valid <= 1'b0;
			irq_num <= 5'h00;
			irq_level <= 2'h3;
			irq_vector <= `IRQ_VECTOR_TOP;
		end
		else if (clk_en)
		begin
			irq_valid <= found;
			irq_num <= pick_num;
			irq_level <= pick_level;
			// upper byte address; lower byte is this plus one
			irq_vector <= `IRQ_VECTOR_TOP - {10'h000, pick_num, 1'b0};
		end
	end

	// axi write path: address and data are accepted in either order
	assign do_write = aw_have && w_have && !s_axi_bvalid;

	always_comb
	begin
		next_bresp = `IRQ_DECERR;
		if (aw_addr[1:0] == 2'h0 && aw_addr < `IRQ_PEND_OFFSET)
			next_bresp = `IRQ_OKAY;
	end

	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			aw_have <= 1'b0;
			w_have <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `IRQ_OKAY;
		end
		else if (clk_en)
		begin
			s_axi_awready <= !aw_have && !s_axi_awready;
			s_axi_wready <= !w_have && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_have <= 1'b1;
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_have <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write)
			begin
				aw_have <= 1'b0;
				w_have <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= next_bresp;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// level registers, byte lane 0 only; reset to the weakest level
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			for (int i = 0; i < `IRQ_LEVEL_REGS; i++)
				level_reg[i] <= `IRQ_LEVEL_RESET;
		end
		else if (clk_en && do_write && next_bresp == `IRQ_OKAY && w_strb[0])
			level_reg[aw_addr[4:2]] <= w_data[7:0];
	end

	// axi read path: one cycle to answer
	assign rd_index = s_axi_araddr[4:2];

	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			rd_state <= irq_map_pkg::rd_idle;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `IRQ_OKAY;
		end
		else if (clk_en)
		begin
			case (rd_state)
				irq_map_pkg::rd_idle:
				begin
					s_axi_arready <= 1'b1;
					if (s_axi_arvalid && s_axi_arready)
					begin
						s_axi_arready <= 1'b0;
						s_axi_rvalid <= 1'b1;
						s_axi_rresp <= `IRQ_OKAY;
						rd_state <= irq_map_pkg::rd_resp;
						if (s_axi_araddr[1:0] != 2'h0)
						begin
							s_axi_rdata <= 32'h00000000;
							s_axi_rresp <= `IRQ_DECERR;
						end
						else if (s_axi_araddr < `IRQ_PEND_OFFSET)
							s_axi_rdata <= {24'h000000, level_reg[rd_index]};
						else if (s_axi_araddr == `IRQ_PEND_OFFSET)
							s_axi_rdata <= {8'h00, sync2};
						else if (s_axi_araddr == `IRQ_GRANT_OFFSET)
							s_axi_rdata <= {irq_vector, 7'h00, irq_valid, 1'b0,
								irq_level, irq_num};
						else
						begin
							s_axi_rdata <= 32'h00000000;
							s_axi_rresp <= `IRQ_DECERR;
						end
					end
				end
				irq_map_pkg::rd_resp:
				begin
					if (s_axi_rready)
					begin
						s_axi_rvalid <= 1'b0;
						rd_state <= irq_map_pkg::rd_idle;
					end
				end
				default:
					rd_state <= irq_map_pkg::rd_idle;
			endcase
		end
	end

	// vector follows the number two bytes per step
	vector_step_a: assert property (@(posedge mclk) disable iff (!nrst)
		irq_vector == 16'hFFFA - {10'h000, irq_num, 1'b0})
		else $error("vector address does not match request number");

	// a source seen on an enabled edge has passed both stages two enabled edges later
	sequence through_sync(logic src_bit);
		clk_en && src_bit ##1 clk_en ##1 clk_en;
	endsequence

	pair_zero_a: assert property (@(posedge mclk) disable iff (!nrst)
		through_sync(ext_irq[4]) |-> sync2[0])
		else $error("channel 4 did not raise request zero");

	generate
		for (g = 0; g < 4; g++)
		begin : pair_chk
			pair_low_a: assert property (@(posedge mclk) disable iff (!nrst)
				through_sync(ext_irq[g]) |-> sync2[g])
				else $error("low external channel missing on its line");
			pair_high_a: assert property (@(posedge mclk) disable iff (!nrst)
				through_sync(ext_irq[g + 4]) |-> sync2[g])
				else $error("high external channel missing on its line");
		end
	endgenerate

	req16_reload_a: assert property (@(posedge mclk) disable iff (!nrst)
		through_sync(reload1_irq) |-> sync2[16])
		else $error("reload timer request not seen on line 16");

	req17_pos_a: assert property (@(posedge mclk) disable iff (!nrst)
		through_sync(multi_pulse_generator_position_irq) |-> sync2[17])
		else $error("position request not seen on line 17");

	req4_uart_a: assert property (@(posedge mclk) disable iff (!nrst)
		through_sync(uart0_irq) |-> sync2[4])
		else $error("uart request not seen on line 4");

	ctimer0_lo_a: assert property (@(posedge mclk) disable iff (!nrst)
		through_sync(ctimer0_lo_irq) |-> sync2[5])
		else $error("timer 0 lower half not on line 5");

	ctimer1_hi_a: assert property (@(posedge mclk) disable iff (!nrst)
		through_sync(ctimer1_hi_irq) |-> sync2[14])
		else $error("timer 1 upper half not on line 14");

	bvalid_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
		clk_en && s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped before it was taken");

	rvalid_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
		clk_en && s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read response dropped before it was taken");

	level_write_a: assert property (@(posedge mclk) disable iff (!nrst)
		clk_en && do_write && next_bresp == 2'h0 && w_strb[0]
		|=> level_reg[$past(aw_addr[4:2])] == $past(w_data[7:0]))
		else $error("level register write lost");

	prio_low_a: assert property (@(posedge mclk) disable iff (!nrst)
		clk_en && found |=> irq_valid
		&& !($past(sync2[0]) && $past(levels[1:0]) <= irq_level && irq_num != 5'h00))
		else $error("request zero not served first");

	req16_or_a: assert property (@(posedge mclk) disable iff (!nrst)
		through_sync(i2c0_irq) |-> sync2[16])
		else $error("i2c request not seen on line 16");

	req4_trip_a: assert property (@(posedge mclk) disable iff (!nrst)
		through_sync(dead_time_trip_input_irq) |-> sync2[4])
		else $error("trip request not seen on line 4");

	ctimer_map_a: assert property (@(posedge mclk) disable iff (!nrst)
		through_sync(ctimer1_lo_irq) |-> sync2[22])
		else $error("timer 1 lower half not on line 22");

	valid_follow_a: assert property (@(posedge mclk) disable iff (!nrst)
		clk_en && sync2 == 24'h000000 |=> !irq_valid)
		else $error("request shown with nothing pending");
endmodule : irq_vector_map

/* File: dv/cpu_core_model.sv */
// processor core side: takes the granted vector and forms the two fetch addresses
module cpu_core_model (
	input wire logic mclk,
	input wire logic irq_valid,
	input wire irq_map_pkg::vector_t irq_vector,
	output irq_map_pkg::vector_t fetch_hi,
	output irq_map_pkg::vector_t fetch_lo
);
	timeunit 1ns;
	timeprecision 1ns;
	// a shared line names no single source: the handler still reads the peripheral flags
	always_ff @(posedge mclk)
	begin
		if (irq_valid)
		begin
			fetch_hi <= irq_vector;
			fetch_lo <= irq_vector + 16'h0001;
		end
	end
endmodule : cpu_core_model

/* File: dv/tb_interrupt_vector_priority_map.sv */
// self-checking bench for the interrupt map
`include "irq_map_defs.svh"
module tb_interrupt_vector_priority_map;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 0, nrst = 0;
	logic clk_en = 1;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [32:0] src = '0;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, irq_valid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [31:0] s_axi_rdata, d;
	irq_map_pkg::req_num_t irq_num;
	irq_map_pkg::level_t irq_level;
	irq_map_pkg::vector_t irq_vector, fetch_lo;
	int n_errors = 0, check_count = 0;
	// source bit to request line, in port order after the eight external channels
	localparam logic [4:0] line_of [33] = '{0, 1, 2, 3, 0, 1, 2, 3, 4, 4, 5, 6, 7, 8, 9, 10,
		11, 12, 13, 14, 15, 16, 16, 16, 17, 17, 18, 19, 19, 20, 21, 22, 23};
	irq_vector_map irq_vector_map_i (.mclk(mclk), .nrst(nrst), .clk_en(clk_en),
		.ext_irq(src[7:0]), .uart0_irq(src[8]), .dead_time_trip_input_irq(src[9]),
		.ctimer0_lo_irq(src[10]), .ctimer0_hi_irq(src[11]), .lin_rx_irq(src[12]),
		.lin_tx_irq(src[13]), .pulse1_lo_irq(src[14]), .pulse1_hi_irq(src[15]),
		.pulse2_hi_irq(src[16]), .pulse0_hi_irq(src[17]), .pulse0_lo_irq(src[18]),
		.ctimer1_hi_irq(src[19]), .pulse2_lo_irq(src[20]), .reload1_irq(src[21]),
		.multi_pulse_generator_write_irq(src[22]), .i2c0_irq(src[23]),
		.programmable_pulse_unit1_irq(src[24]),
		.multi_pulse_generator_position_irq(src[25]), .adc_irq(src[26]),
		.timebase_irq(src[27]),
		.watch_irq(src[28]), .comp0_irq(src[29]), .comp1_irq(src[30]),
		.ctimer1_lo_irq(src[31]), .flash_irq(src[32]), .irq_valid(irq_valid),
		.irq_num(irq_num), .irq_level(irq_level), .irq_vector(irq_vector),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready));
	cpu_core_model cpu_core_model_i (.mclk(mclk), .irq_valid(irq_valid),
		.irq_vector(irq_vector), .fetch_hi(), .fetch_lo(fetch_lo));
	initial
	begin
		forever #25 mclk = ~mclk;
	end
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
		logic done;
		done = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!done)
		begin
			@(posedge mclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid && s_axi_bready)
			begin
				resp = s_axi_bresp;
				s_axi_bready <= 0;
				done = 1;
			end
		end
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge mclk); while (!(s_axi_arvalid && s_axi_arready));
		s_axi_arvalid <= 0;
		do @(posedge mclk); while (!s_axi_rvalid);
		v = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 0;
	endtask : rd
	task automatic settle();
		repeat (5) @(posedge mclk);
	endtask : settle
	// every source alone: line number and vector address
	task automatic test_sources();
		logic [15:0] v;
		for (int i = 0; i < 33; i++)
		begin
			src <= 33'h1 << i;
			settle();
			v = `IRQ_VECTOR_TOP - 16'(line_of[i]) * `IRQ_VECTOR_STEP;
			chk("valid", 32'(irq_valid), 32'h1);
			chk("num", 32'(irq_num), 32'(line_of[i]));
			chk("vector", 32'(irq_vector), 32'(v));
			chk("fetch_lo", 32'(fetch_lo), 32'(v + 16'h0001));
			src <= '0;
			settle();
			chk("idle", 32'(irq_valid), 32'h0);
		end
		$display("test_sources done");
	endtask : test_sources
	// enable low freezes the request path; pending and grant words read back
	task automatic test_freeze();
		clk_en <= 0;
		src <= 33'h1 << 32;
		settle();
		chk("frozen", 32'(irq_valid), 32'h0);
		clk_en <= 1;
		settle();
		chk("woken", 32'({irq_valid, irq_num}), 32'({1'b1, 5'h17}));
		rd(8'h18, d, r);
		chk("pending", d, 32'h0080_0000);
		rd(8'h1C, d, r);
		chk("grant", d, {16'hFFCC, 7'h00, 1'b1, 1'b0, 2'h3, 5'h17});
		src <= '0;
		settle();
		$display("test_freeze done");
	endtask : test_freeze
	// lines 5 and 23 together under level changes
	task automatic test_priority();
		src <= (33'h1 << 10) | (33'h1 << 32);
		settle();
		chk("tie 3", 32'(irq_num), 32'h5);
		wr(`IRQ_LEVEL_BASE + 8'h14, 32'h3F, r);
		settle();
		chk("lvl win", 32'({irq_num, irq_level}), 32'({5'h17, 2'h0}));
		wr(`IRQ_LEVEL_BASE + 8'h04, 32'hF3, r);
		settle();
		chk("tie 0", 32'({irq_num, irq_level}), 32'({5'h05, 2'h0}));
		src <= '0;
		$display("test_priority done");
	endtask : test_priority
	// level registers, upper bits, unmapped place
	task automatic test_regs();
		for (int i = 0; i < 6; i++)
		begin
			wr(8'(4 * i), 32'hABCD_0090 | 32'(i), r);
			chk("wr resp", 32'(r), 32'h0);
			rd(8'(4 * i), d, r);
			chk("rd data", d, 32'h90 | 32'(i));
		end
		wr(8'h24, 32'h0, r);
		chk("wr unmapped", 32'(r), 32'(`IRQ_DECERR));
		rd(8'h24, d, r);
		chk("rd unmapped", 32'(r), 32'(`IRQ_DECERR));
		s_axi_wstrb <= 4'hE;
		wr(8'h00, 32'h55, r);
		s_axi_wstrb <= 4'hF;
		rd(8'h00, d, r);
		chk("strobe off", d, 32'h90);
		$display("test_regs done");
	endtask : test_regs
	task automatic test_done();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : test_done
	initial
	begin
		repeat (6) @(posedge mclk);
		nrst <= 1;
		@(posedge mclk);
		rd(`IRQ_LEVEL_BASE + 8'h08, d, r);
		chk("level reset", d, 32'h0000_00FF);
		test_sources();
		test_freeze();
		test_priority();
		test_regs();
		test_done();
	end
	initial
	begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		test_done();
	end
endmodule : tb_interrupt_vector_priority_map
